// file: common/pmc_pkg.sv
// package of constants and types for the periodic modulo counter
package pmc_pkg;

  // ==========================================================================
  // register indices (byte address = 4 * index)
  localparam logic [3:0] PMC_IDX_CTRL_ONE = 4'h0;  // control_status_one
  localparam logic [3:0] PMC_IDX_CTRL_TWO = 4'h1;  // control_status_two
  localparam logic [3:0] PMC_IDX_LIM_HI = 4'h2;    // compare_limit_high
  localparam logic [3:0] PMC_IDX_LIM_LO = 4'h3;    // compare_limit_low
  localparam logic [3:0] PMC_IDX_CNT_HI = 4'h4;    // count_value_high
  localparam logic [3:0] PMC_IDX_CNT_LO = 4'h5;    // count_value_low
  localparam logic [3:0] PMC_IDX_IRQ_STAT = 4'h6;  // interrupt status, read only
  localparam logic [3:0] PMC_IDX_IRQ_CLR = 4'h7;   // interrupt clear, write only
  localparam logic [3:0] PMC_IDX_IRQ_EN = 4'h8;    // interrupt enable

  // ==========================================================================
  // field positions
  localparam int PMC_BIT_FLAG = 7;        // periodic_flag in control_status_one
  localparam int PMC_BIT_IRQ_EN = 6;      // periodic_irq_enable
  localparam int PMC_BIT_TOGGLE_EN = 4;   // toggle_out_enable
  localparam int PMC_POS_SRC = 6;         // source_select, two bits
  localparam int PMC_POS_DIV = 0;         // divider_select, three bits
  localparam int PMC_BIT_EVT = 0;         // event bit in status/clear/enable

  // ==========================================================================
  // reset values
  localparam logic [1:0] PMC_RST_SRC = 2'h0;
  localparam logic [2:0] PMC_RST_DIV = 3'h0;
  localparam logic [15:0] PMC_RST_LIMIT = 16'h0000;
  localparam logic [15:0] PMC_RST_COUNT = 16'h0000;

  // ==========================================================================
  // codes
  localparam logic [1:0] PMC_SRC_EXT = 2'h0;
  localparam logic [1:0] PMC_SRC_LPO = 2'h1;
  localparam logic [2:0] PMC_DIV_OFF = 3'h0;
  localparam logic [1:0] PMC_HTRANS_NONSEQ = 2'h2;

  // ==========================================================================
  // latched address phase of an ahb transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] idx;
  } pmc_req_s;

endpackage : pmc_pkg

// file: design/pmc_top.sv
// periodic modulo counter with prescaler, ahb-lite registers and toggle pin
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns

module pmc_top
  import pmc_pkg::*;
#(
  parameter int PRESC_W = 11  // prescaler counter width, holds 2047
) (
  input wire logic core_clk,            // 100 MHz clock, also the bus clock source
  input wire logic srst,                // synchronous reset, active high
  input wire logic ext_osc_in,          // external_oscillator clock, asynchronous
  input wire logic lpo_in,              // low_power_oscillator clock, asynchronous
  input wire logic hsel,                // ahb slave select
  input wire logic [31:0] haddr,        // ahb address
  input wire logic [1:0] htrans,        // ahb transfer type
  input wire logic hwrite,              // ahb write
  input wire logic [2:0] hsize,         // ahb size, word only
  input wire logic [31:0] hwdata,       // ahb write data
  input wire logic hready,              // ahb bus ready
  output logic [31:0] hrdata,           // ahb read data
  output logic hreadyout,               // ahb slave ready
  output logic hresp,                   // ahb response, always okay
  output logic irq,                     // level interrupt
  output logic toggle_out               // overflow toggle pin
);

  // ==========================================================================
  // divide ratio lookup
  function automatic logic [PRESC_W-1:0] div_ratio(input logic src_lo, input logic [2:0] code);
    logic [PRESC_W-1:0] r;
    r = PRESC_W'(1);
    if (!src_lo) begin
      r = PRESC_W'(1) << (code - 3'h1);
    end else begin
      case (code)
        3'h6: r = PRESC_W'(100);
        3'h7: r = PRESC_W'(1000);
        default: r = PRESC_W'(128) << (code - 3'h1);
      endcase
    end
    return r;
  endfunction : div_ratio

  // ==========================================================================
  // state
  logic [1:0] source_select;
  logic [2:0] divider_select;
  logic periodic_flag;
  logic periodic_irq_enable;
  logic toggle_out_enable;
  logic [15:0] compare_limit;      // software-visible limit
  logic [15:0] active_limit;       // limit used by the comparator
  logic [15:0] tick_counter;
  logic [PRESC_W-1:0] presc_cnt;
  logic [7:0] count_upper_byte;    // frozen upper half
  logic snap_held;
  logic [2:0] ext_sync;
  logic [2:0] lpo_sync;
  pmc_req_s req;

  // ==========================================================================
  // bus decode; hreadyout goes high one cycle after reset is released and stays high, so no wait states exist
  // writes land at the end of the data phase, reads are sampled in the address
  // phase, so a read right behind a write to the same register returns the old value
  logic take;
  logic [3:0] take_idx;
  logic wr;
  logic [7:0] wbyte;
  logic ctrl2_wr;
  logic cfg_change;
  logic [1:0] next_src;
  logic [2:0] next_div;

  assign take = hsel && hready && (htrans == PMC_HTRANS_NONSEQ);
  assign take_idx = haddr[5:2];
  assign wr = req.valid && req.write;
  assign wbyte = hwdata[7:0];
  assign ctrl2_wr = wr && (req.idx == PMC_IDX_CTRL_TWO);
  assign next_src = wbyte[PMC_POS_SRC +: 2];
  assign next_div = wbyte[PMC_POS_DIV +: 3];
  assign cfg_change = ctrl2_wr && ((next_src != source_select) ||
                                   (next_div != divider_select));

  // write strobes belong to the data phase, read strobes to the address phase
  logic wr_ctrl1;
  logic wr_lim_hi;
  logic wr_lim_lo;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic rd_cnt_lo;
  logic rd_cnt_hi;
  assign wr_ctrl1 = wr && (req.idx == PMC_IDX_CTRL_ONE);
  assign wr_lim_hi = wr && (req.idx == PMC_IDX_LIM_HI);
  assign wr_lim_lo = wr && (req.idx == PMC_IDX_LIM_LO);
  assign wr_irq_en = wr && (req.idx == PMC_IDX_IRQ_EN);
  assign wr_irq_clr = wr && (req.idx == PMC_IDX_IRQ_CLR);
  assign rd_cnt_lo = take && !hwrite && (take_idx == PMC_IDX_CNT_LO);
  assign rd_cnt_hi = take && !hwrite && (take_idx == PMC_IDX_CNT_HI);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      req <= '0;
    end else begin
      req.valid <= take;
      req.write <= hwrite;
      req.idx <= take_idx;
    end
  end

  // ==========================================================================
  // clock source synchronisers; stage 0 is read only by stage 1
  // a source edge is seen two to three cycles late; a source must stay well
  // below half the core clock, otherwise edges are lost
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_sync <= 3'h0;
      lpo_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_osc_in};
      lpo_sync <= {lpo_sync[1:0], lpo_in};
    end
  end

  logic src_edge;
  always_comb begin
    case (source_select)
      PMC_SRC_EXT: src_edge = ext_sync[1] && !ext_sync[2];
      PMC_SRC_LPO: src_edge = lpo_sync[1] && !lpo_sync[2];
      default: src_edge = 1'b1;  // bus clock
    endcase
  end

  // ==========================================================================
  // prescaler
  logic presc_tick;
  logic [PRESC_W-1:0] ratio;
  assign ratio = div_ratio(source_select[0], divider_select);
  assign presc_tick = (divider_select != PMC_DIV_OFF) && src_edge &&
                      (presc_cnt == ratio - PRESC_W'(1));

  // the prescaler counts source edges, not core cycles, so the bus source
  // (an edge every cycle) and the slow sources share one path
  logic [PRESC_W-1:0] next_presc_cnt;
  always_comb begin
    next_presc_cnt = presc_cnt;
    if (presc_tick) begin
      next_presc_cnt = '0;
    end else if (src_edge) begin
      next_presc_cnt = presc_cnt + PRESC_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || cfg_change || divider_select == PMC_DIV_OFF) begin
      presc_cnt <= '0;
    end else begin
      presc_cnt <= next_presc_cnt;
    end
  end

  // ==========================================================================
  // main counter and comparator
  logic overflow;
  assign overflow = presc_tick && (tick_counter == active_limit);

  // the match is checked against the latched limit, never the written one,
  // so a limit below the current count only bites after the next wrap
  logic [15:0] next_tick_counter;
  always_comb begin
    next_tick_counter = tick_counter;
    if (overflow) begin
      next_tick_counter = 16'h0000;
    end else if (presc_tick) begin
      next_tick_counter = tick_counter + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || cfg_change) begin
      tick_counter <= PMC_RST_COUNT;
    end else begin
      tick_counter <= next_tick_counter;
    end
  end

  // a limit written mid-period waits for the next overflow or a control_status_two write that changes the divider to a nonzero code
  always_ff @(posedge core_clk) begin
    if (srst) begin
      active_limit <= PMC_RST_LIMIT;
    end else if (overflow) begin
      active_limit <= compare_limit;
    end else if (ctrl2_wr && next_div != PMC_DIV_OFF && next_div != divider_select) begin
      active_limit <= compare_limit;
    end
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      source_select <= PMC_RST_SRC;
      divider_select <= PMC_RST_DIV;
    end else if (ctrl2_wr) begin
      source_select <= next_src;
      divider_select <= next_div;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_limit <= PMC_RST_LIMIT;
    end else if (wr_lim_hi) begin
      compare_limit[15:8] <= wbyte;
    end else if (wr_lim_lo) begin
      compare_limit[7:0] <= wbyte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      periodic_irq_enable <= 1'b0;
      toggle_out_enable <= 1'b0;
    end else if (wr_ctrl1) begin
      periodic_irq_enable <= wbyte[PMC_BIT_IRQ_EN];
      toggle_out_enable <= wbyte[PMC_BIT_TOGGLE_EN];
    end else if (wr_irq_en) begin
      periodic_irq_enable <= wbyte[PMC_BIT_EVT];
    end
  end

  // ==========================================================================
  // periodic flag: a match in the clearing cycle keeps the flag set
  logic flag_clr;
  assign flag_clr = (wr_ctrl1 && wbyte[PMC_BIT_FLAG]) ||
                    (wr_irq_clr && wbyte[PMC_BIT_EVT]);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      periodic_flag <= 1'b0;
    end else if (overflow) begin
      periodic_flag <= 1'b1;
    end else if (flag_clr) begin
      periodic_flag <= 1'b0;
    end
  end

  // irq is registered, so it looks ahead at this cycle's set, clear and enable
  // writes; it then moves together with the flag instead of one cycle behind
  logic next_flag;
  logic next_irq_en;
  logic next_irq;
  always_comb begin
    next_flag = periodic_flag;
    if (overflow) begin
      next_flag = 1'b1;
    end else if (flag_clr) begin
      next_flag = 1'b0;
    end
  end

  always_comb begin
    next_irq_en = periodic_irq_enable;
    if (wr_ctrl1) begin
      next_irq_en = wbyte[PMC_BIT_IRQ_EN];
    end else if (wr_irq_en) begin
      next_irq_en = wbyte[PMC_BIT_EVT];
    end
  end

  assign next_irq = next_flag && next_irq_en;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      toggle_out <= 1'b0;
    end else if (overflow && toggle_out_enable) begin
      toggle_out <= !toggle_out;
    end
  end

  // ==========================================================================
  // read path; count registers have no write decode at all
  // the snapshot holds only the upper byte: the lower byte is returned live at
  // the same edge, so the pair is consistent; a high read without a low read
  // first sees the live count and may tear against a later low read
  always_ff @(posedge core_clk) begin
    if (srst) begin
      snap_held <= 1'b0;
      count_upper_byte <= 8'h00;
    end else if (rd_cnt_lo) begin
      snap_held <= 1'b1;
      count_upper_byte <= tick_counter[15:8];
    end else if (rd_cnt_hi) begin
      snap_held <= 1'b0;
    end
  end

  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    case (take_idx)
      PMC_IDX_CTRL_ONE: begin
        rbyte[PMC_BIT_FLAG] = periodic_flag;
        rbyte[PMC_BIT_IRQ_EN] = periodic_irq_enable;
        rbyte[PMC_BIT_TOGGLE_EN] = toggle_out_enable;
      end
      PMC_IDX_CTRL_TWO: begin
        rbyte[PMC_POS_SRC +: 2] = source_select;
        rbyte[PMC_POS_DIV +: 3] = divider_select;
      end
      PMC_IDX_LIM_HI: rbyte = compare_limit[15:8];
      PMC_IDX_LIM_LO: rbyte = compare_limit[7:0];
      PMC_IDX_CNT_HI: rbyte = snap_held ? count_upper_byte : tick_counter[15:8];
      PMC_IDX_CNT_LO: rbyte = tick_counter[7:0];
      PMC_IDX_IRQ_STAT: rbyte[PMC_BIT_EVT] = periodic_flag;
      PMC_IDX_IRQ_EN: rbyte[PMC_BIT_EVT] = periodic_irq_enable;
      default: rbyte = 8'h00;
    endcase
  end

  // read data is captured at the address edge and stands until the next read,
  // which keeps hrdata a plain flop at the cost of reading one cycle early
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite) begin
        hrdata <= {24'h000000, rbyte};
      end
    end
  end

endmodule : pmc_top

// file: sim/pmc_sva.sv
// port checker for the periodic modulo counter
`timescale 1ns/1ns
module pmc_sva (
  input wire logic core_clk, // clock
  input wire logic srst, // sync reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic irq, // interrupt
  input wire logic toggle_out // toggle pin
);
  // ==========
  // shadow of the enables, rebuilt from bus writes
  logic dv;
  logic dw;
  logic [3:0] di;
  logic en;
  logic te;
  logic clr;
  always_ff @(posedge core_clk) begin
    dv <= !srst && hsel && hready && htrans == 2'h2;
    dw <= hwrite;
    di <= haddr[5:2];
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en <= 1'b0;
      te <= 1'b0;
      clr <= 1'b0;
    end else begin
      clr <= dv && dw && (di == 4'h7 ? hwdata[0] : (di == 4'h0 && hwdata[7]));
      if (dv && dw && di == 4'h0) begin
        en <= hwdata[6];
        te <= hwdata[4];
      end
      if (dv && dw && di == 4'h8) begin
        en <= hwdata[0];
      end
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_rst_idle: assert property (disable iff (1'b0) srst |=> !irq && !toggle_out)
    else $error("outputs not idle after reset");
  a_irq_needs_en: assert property ($rose(irq) && !$past(srst) |-> en)
    else $error("interrupt rose while disabled");
  a_tog_needs_en: assert property (toggle_out != $past(toggle_out) && !$past(srst) |-> $past(te))
    else $error("pin toggled while disabled");
  a_tog_with_irq: assert property (toggle_out != $past(toggle_out) && en |=> irq)
    else $error("toggle without flag");
  a_irq_fall: assert property ($fell(irq) && !$past(srst) |-> clr || !en)
    else $error("interrupt dropped without cause");
  a_irq_hold: assert property (irq && en && !clr |=> irq || clr || !en)
    else $error("interrupt dropped early");
  a_zero_wait: assert property (!srst |=> hreadyout)
    else $error("slave stalled");
  a_resp_okay: assert property (!hresp)
    else $error("response not okay");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property (toggle_out != $past(toggle_out));
endmodule : pmc_sva

// file: sim/pmc_top_bench.sv
// self-checking bench for the periodic modulo counter
`timescale 1ns/1ns
module pmc_top_bench;
  import pmc_pkg::*;
  logic core_clk, srst, hsel, hwrite;
  logic ext_osc_in = 1'b0;
  logic lpo_in = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, irq, toggle_out;
  wire logic hready;
  int error_cnt, num_checks, n;
  int cyc = 0;
  int dec[8] = '{0, 128, 256, 512, 1024, 2048, 100, 1000};
  assign hready = hreadyout;
  pmc_top u_dut (.core_clk(core_clk), .srst(srst), .ext_osc_in(ext_osc_in),
    .lpo_in(lpo_in), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .toggle_out(toggle_out));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // oscillators are exact multiples of the clock so gaps are exact
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    ext_osc_in <= cyc[3];
    lpo_in <= cyc[4];
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ==========
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {26'h0, idx, 2'h0};
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask : bus
  task automatic cfg(input logic [1:0] s, input logic [2:0] d, input logic [15:0] lim);
    bus(1'b1, 4'h2, {24'h0, lim[15:8]});
    bus(1'b1, 4'h3, {24'h0, lim[7:0]});
    bus(1'b1, 4'h1, 32'h0);
    bus(1'b1, 4'h1, {24'h0, s, 3'h0, d});
  endtask : cfg
  task automatic nxt(output int c);
    logic t;
    t = toggle_out;
    c = 0;
    while (toggle_out === t && c < 9000) begin
      @(posedge core_clk);
      c++;
    end
  endtask : nxt
  task automatic per(input int e);
    nxt(n);
    nxt(n);
    chk(n, e);
  endtask : per
  // ==========
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 16; i++) begin
      if (i != 7 && (i < 9 || i == 15)) begin
        bus(1'b0, i[3:0], 32'h0);
        chk(rd, 32'h0);
      end
    end
    bus(1'b1, 4'h1, 32'h80);
    repeat (30) @(posedge core_clk);
    bus(1'b0, 4'h5, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_rates;
    bus(1'b1, 4'h0, 32'h10);
    for (int d = 1; d < 8; d++) begin
      cfg(2'h2, d[2:0], 16'h3);
      per(4 << (d - 1));
      cfg(2'h3, d[2:0], 16'h0);
      per(dec[d]);
    end
    cfg(2'h0, 3'h1, 16'h3);
    per(64);
    cfg(2'h1, 3'h1, 16'h0);
    per(4096);
  endtask : t_rates
  task automatic t_latch;
    cfg(2'h2, 3'h1, 16'h7);
    per(8);
    bus(1'b1, 4'h3, 32'hF);
    nxt(n);
    chk({31'h0, n <= 8}, 32'h1);
    per(16);
  endtask : t_latch
  task automatic t_snap;
    cfg(2'h2, 3'h1, 16'hFFFF);
    bus(1'b0, 4'h5, 32'h0);
    repeat (300) @(posedge core_clk);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 4'h4, 32'hAB);
    bus(1'b1, 4'h5, 32'hCD);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, 4'h1, 32'h81);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, 4'h1, 32'h82);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h0);
  endtask : t_snap
  task automatic t_irq;
    cfg(2'h3, 3'h7, 16'h0);
    bus(1'b1, 4'h7, 32'h1);
    bus(1'b1, 4'h8, 32'h1);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (irq !== 1'b1 && n < 1100) begin
        @(posedge core_clk);
        n++;
      end
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, (k == 0) ? 4'h7 : 4'h0, (k == 0) ? 32'h1 : 32'h50);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, {31'h0, k[0]});
    end
    bus(1'b1, 4'h0, 32'h10);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 4'h6, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, 4'h0, 32'h90);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h10);
  endtask : t_irq
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    srst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {error_cnt, num_checks} = '0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    t_reset();
    t_rates();
    t_latch();
    t_snap();
    t_irq();
    wrap_up();
  end
endmodule : pmc_top_bench
bind pmc_top pmc_sva u_sva (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .toggle_out(toggle_out));
